// file: ipf_pkg.sv
// constants, types and field map of the interrupt priority field bank
// Function
// - field code seven gives its source level seven; middle codes give matching levels
// - field code one gives its source the lowest active level, one
// - field code zero disables the source; it never raises a request
// - at reset every field loads binary 100, level four
// - bits without a field read zero; field bits are read and write
// - third register: adc done in bits 6-4, uart A transmit in 2-0
// - fourth register: pin change 14-12, comparator 10-8, i2c master 6-4, slave 2-0
// - fifth register: capture 8 in 14-12, capture 7 in 10-8, external one 2-0
// - sixth register: timer four 14-12, compare 4 in 10-8, compare 3 in 6-4
// - seventh register: uart B tx 14-12, rx 10-8, external two 6-4, timer five 2-0
// - eighth register: spi B event in bits 6-4, spi B fault in 2-0
package ipf_pkg;

    localparam int DATA_W  = 32;
    localparam int ADDR_W  = 5;
    localparam int BE_W    = DATA_W / 8;
    localparam int LANE_W  = 8;
    localparam int FIELD_W = 3;
    localparam int NUM_SRC = 18;
    localparam int NUM_REG = 6;
    localparam int IDX_W   = 3;

    typedef logic [FIELD_W-1:0]           ipf_prio_t;
    typedef ipf_prio_t [NUM_SRC-1:0]      ipf_fields_t;
    typedef logic [IDX_W-1:0]             ipf_idx_t;

    // priority codes with a meaning of their own
    localparam ipf_prio_t PRIO_OFF   = 3'h0;
    localparam ipf_prio_t PRIO_LOW   = 3'h1;
    localparam ipf_prio_t PRIO_HIGH  = 3'h7;
    localparam ipf_prio_t PRIO_RESET = 3'h4;
    localparam ipf_fields_t FIELDS_RESET = {NUM_SRC{PRIO_RESET}};

    // byte address of each register, one aligned word apiece
    localparam logic [ADDR_W-1:0] REG_OFS [NUM_REG] =
        '{5'h00, 5'h04, 5'h08, 5'h0C, 5'h10, 5'h14};
    localparam ipf_idx_t IDX_NONE = 3'h7;

    // source order: adc, uart A tx, pin change, comparator, i2c master, i2c slave,
    // capture 8, capture 7, ext one, timer four, compare 4, compare 3,
    // uart B tx, uart B rx, ext two, timer five, spi B event, spi B fault
    localparam int SRC_REG [NUM_SRC] =
        '{0, 0, 1, 1, 1, 1, 2, 2, 2, 3, 3, 3, 4, 4, 4, 4, 5, 5};
    localparam int SRC_LSB [NUM_SRC] =
        '{4, 0, 12, 8, 4, 0, 12, 8, 0, 12, 8, 4, 12, 8, 4, 0, 4, 0};

    // source indices that other files refer to by name
    localparam int SRC_ADC        = 0;
    localparam int SRC_PIN_CHANGE = 2;
    localparam int SRC_EXT_ONE    = 8;
    localparam int SRC_CMP3       = 11;
    localparam int SRC_TIMER_FIVE = 15;
    localparam int SRC_SPI_FAULT  = 17;

    // avalon request group driven by the master
    typedef struct packed {
        logic              read;
        logic              write;
        logic [ADDR_W-1:0] address;
        logic [DATA_W-1:0] writedata;
        logic [BE_W-1:0]   byteenable;
    } ipf_avs_req_s;

    // bus phase: stall while the word is fetched, then answer
    typedef enum logic [0:0] {
        BUS_ANSWER = 1'b0,
        BUS_WAIT   = 1'b1
    } ipf_bus_e;

endpackage : ipf_pkg

// file: ipf_prio_bank.sv
// priority field bank with avalon slave and per-source request gating
//
// The implementer's own choices: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module ipf_prio_bank (
    input  wire logic                        clk,
    input  wire logic                        sys_rst,
    input  wire ipf_pkg::ipf_avs_req_s       avs_req,
    output logic [ipf_pkg::DATA_W-1:0]       avs_readdata,
    output logic                             avs_waitrequest,
    input  wire logic [ipf_pkg::NUM_SRC-1:0] src_flag,
    input  wire logic [ipf_pkg::NUM_SRC-1:0] src_enable,
    output logic [ipf_pkg::NUM_SRC-1:0]      src_req,
    output ipf_pkg::ipf_fields_t             src_level
);
    import ipf_pkg::*;

    typedef struct packed {
        ipf_bus_e          phase;
        logic [DATA_W-1:0] readdata;
        ipf_fields_t       field;
        logic [NUM_SRC-1:0] req;
        ipf_fields_t       level;
    } ipf_state_s;

    localparam ipf_state_s ST_RESET = '{
        phase:    BUS_WAIT,
        readdata: '0,
        field:    FIELDS_RESET,
        req:      '0,
        level:    FIELDS_RESET
    };

    ipf_state_s         st;
    ipf_state_s         next_st;
    logic [NUM_SRC-1:0] gate_req;
    ipf_fields_t        gate_level;
    ipf_idx_t           hit_idx;
    logic               wr_take;
    logic               rd_fetch;

    // source indices that only the checks below name
    localparam int SRC_UART_A_TX  = 1;
    localparam int SRC_COMPARATOR = 3;
    localparam int SRC_I2C_MASTER = 4;
    localparam int SRC_I2C_SLAVE  = 5;
    localparam int SRC_CAPTURE8   = 6;
    localparam int SRC_CAPTURE7   = 7;
    localparam int SRC_TIMER_FOUR = 9;
    localparam int SRC_CMP4       = 10;
    localparam int SRC_UART_B_TX  = 12;
    localparam int SRC_UART_B_RX  = 13;
    localparam int SRC_EXT_TWO    = 14;
    localparam int SRC_SPI_EVENT  = 16;

    // address to register index, IDX_NONE when unmapped or misaligned
    function automatic ipf_idx_t reg_index(input logic [ADDR_W-1:0] addr);
        ipf_idx_t idx;
        idx = IDX_NONE;
        for (int k = 0; k < NUM_REG; k++) begin
            if (addr == REG_OFS[k]) begin
                idx = IDX_W'(k);
            end
        end
        return idx;
    endfunction : reg_index

    // assemble one register word from the fields it holds
    function automatic logic [DATA_W-1:0] read_word(input ipf_fields_t f,
                                                    input ipf_idx_t idx);
        logic [DATA_W-1:0] w;
        w = '0;
        for (int i = 0; i < NUM_SRC; i++) begin
            if (int'(idx) == SRC_REG[i]) begin
                w[SRC_LSB[i] +: FIELD_W] = f[i];
            end
        end
        return w;
    endfunction : read_word

    // bits of a register word that carry a field
    function automatic logic [DATA_W-1:0] field_mask(input ipf_idx_t idx);
        logic [DATA_W-1:0] m;
        m = '0;
        for (int i = 0; i < NUM_SRC; i++) begin
            if (int'(idx) == SRC_REG[i]) begin
                m[SRC_LSB[i] +: FIELD_W] = {FIELD_W{1'b1}};
            end
        end
        return m;
    endfunction : field_mask

    // per-source decode of the stored codes
    genvar g;
    generate
        for (g = 0; g < NUM_SRC; g++) begin : g_src
            ipf_src_gate u_gate (
                .src_flag   (src_flag[g]),
                .src_enable (src_enable[g]),
                .code       (st.field[g]),
                .request    (gate_req[g]),
                .level      (gate_level[g])
            );
        end
    endgenerate

    // bus decode shared by the next-state logic and the checks
    assign hit_idx  = reg_index(avs_req.address);
    assign wr_take  = avs_req.write && (st.phase == BUS_ANSWER);
    assign rd_fetch = avs_req.read && (st.phase == BUS_WAIT);

    // next state: bus phase, read capture, field writes, gated outputs
    always_comb begin
        next_st       = st;
        next_st.req   = gate_req;
        next_st.level = gate_level;
        unique case (st.phase)
            BUS_WAIT: begin
                if (avs_req.read || avs_req.write) begin
                    next_st.phase = BUS_ANSWER;
                end
                if (rd_fetch) begin
                    next_st.readdata = read_word(st.field, hit_idx);
                end
            end
            BUS_ANSWER: begin
                next_st.phase = BUS_WAIT;
            end
        endcase
        // only field bits are stored, so other written bits fall away
        if (wr_take) begin
            for (int i = 0; i < NUM_SRC; i++) begin
                if (int'(hit_idx) == SRC_REG[i]
                    && avs_req.byteenable[SRC_LSB[i] / LANE_W]) begin
                    next_st.field[i] = avs_req.writedata[SRC_LSB[i] +: FIELD_W];
                end
            end
        end
    end

    // state register
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            st <= ST_RESET;
        end else begin
            st <= next_st;
        end
    end

    // outputs straight from the state register
    assign avs_readdata    = st.readdata;
    assign avs_waitrequest = logic'(st.phase);
    assign src_req         = st.req;
    assign src_level       = st.level;

    // checks on bus timing, reset, field map and gating
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence s_req_pending;
        (avs_req.read || avs_req.write) && avs_waitrequest;
    endsequence

    sequence s_write_taken;
        avs_req.write && !avs_waitrequest;
    endsequence

    sequence s_read_taken;
        avs_req.read && !avs_waitrequest;
    endsequence

    // request is answered on the next cycle, then the stall returns
    a_bus_answer_time: assert property (
        s_req_pending |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("bus answer not one cycle after request");

    // leaving reset every field sits at level four
    a_reset_field_value: assert property (
        $fell(sys_rst) |-> (st.field == FIELDS_RESET) && (src_level == FIELDS_RESET))
        else $error("fields not at reset level after reset");

    // read answer carries zeros outside the fields
    a_read_unused_zero: assert property (
        s_read_taken |-> (avs_readdata & ~field_mask(hit_idx)) == '0)
        else $error("unused bit read as one");

    // read answer returns the stored fields
    a_read_field_value: assert property (
        s_read_taken and (avs_req.address == $past(avs_req.address))
        |-> avs_readdata == read_word($past(st.field), hit_idx))
        else $error("read data does not match stored fields");

    // adc field lands from bits 6-4 of the third register
    a_write_adc_field: assert property (
        s_write_taken and (hit_idx == IDX_W'(SRC_REG[SRC_ADC]))
        and avs_req.byteenable[0]
        |=> st.field[SRC_ADC] == $past(avs_req.writedata[6:4]))
        else $error("adc field not written from bits 6-4");

    // pin change field lands from bits 14-12 of the fourth register
    a_write_pin_field: assert property (
        s_write_taken and (hit_idx == IDX_W'(SRC_REG[SRC_PIN_CHANGE]))
        and avs_req.byteenable[1]
        |=> st.field[SRC_PIN_CHANGE] == $past(avs_req.writedata[14:12]))
        else $error("pin change field not written from bits 14-12");

    // external one field lands from bits 2-0 of the fifth register
    a_write_ext1_field: assert property (
        s_write_taken and (hit_idx == IDX_W'(SRC_REG[SRC_EXT_ONE]))
        and avs_req.byteenable[0]
        |=> st.field[SRC_EXT_ONE] == $past(avs_req.writedata[2:0]))
        else $error("external one field not written from bits 2-0");

    // compare 3 field lands from bits 6-4 of the sixth register
    a_write_cmp3_field: assert property (
        s_write_taken and (hit_idx == IDX_W'(SRC_REG[SRC_CMP3]))
        and avs_req.byteenable[0]
        |=> st.field[SRC_CMP3] == $past(avs_req.writedata[6:4]))
        else $error("compare 3 field not written from bits 6-4");

    // timer five field lands from bits 2-0 of the seventh register
    a_write_tmr5_field: assert property (
        s_write_taken and (hit_idx == IDX_W'(SRC_REG[SRC_TIMER_FIVE]))
        and avs_req.byteenable[0]
        |=> st.field[SRC_TIMER_FIVE] == $past(avs_req.writedata[2:0]))
        else $error("timer five field not written from bits 2-0");

    // spi fault field lands from bits 2-0 of the eighth register
    a_write_spi_fault: assert property (
        s_write_taken and (hit_idx == IDX_W'(SRC_REG[SRC_SPI_FAULT]))
        and avs_req.byteenable[0]
        |=> st.field[SRC_SPI_FAULT] == $past(avs_req.writedata[2:0]))
        else $error("spi fault field not written from bits 2-0");

    // uart A transmit field lands from bits 2-0 of the third register
    a_write_uarta_tx: assert property (
        s_write_taken and (hit_idx == IDX_W'(SRC_REG[SRC_UART_A_TX]))
        and avs_req.byteenable[0]
        |=> st.field[SRC_UART_A_TX] == $past(avs_req.writedata[2:0]))
        else $error("uart A transmit field not written from bits 2-0");

    // comparator field lands from bits 10-8 of the fourth register
    a_write_comparator_field: assert property (
        s_write_taken and (hit_idx == IDX_W'(SRC_REG[SRC_COMPARATOR]))
        and avs_req.byteenable[1]
        |=> st.field[SRC_COMPARATOR] == $past(avs_req.writedata[10:8]))
        else $error("comparator field not written from bits 10-8");

    // i2c master field lands from bits 6-4 of the fourth register
    a_write_i2cm_field: assert property (
        s_write_taken and (hit_idx == IDX_W'(SRC_REG[SRC_I2C_MASTER]))
        and avs_req.byteenable[0]
        |=> st.field[SRC_I2C_MASTER] == $past(avs_req.writedata[6:4]))
        else $error("i2c master field not written from bits 6-4");

    // i2c slave field lands from bits 2-0 of the fourth register
    a_write_i2cs_field: assert property (
        s_write_taken and (hit_idx == IDX_W'(SRC_REG[SRC_I2C_SLAVE]))
        and avs_req.byteenable[0]
        |=> st.field[SRC_I2C_SLAVE] == $past(avs_req.writedata[2:0]))
        else $error("i2c slave field not written from bits 2-0");

    // capture 8 field lands from bits 14-12 of the fifth register
    a_write_cap8_field: assert property (
        s_write_taken and (hit_idx == IDX_W'(SRC_REG[SRC_CAPTURE8]))
        and avs_req.byteenable[1]
        |=> st.field[SRC_CAPTURE8] == $past(avs_req.writedata[14:12]))
        else $error("capture 8 field not written from bits 14-12");

    // capture 7 field lands from bits 10-8 of the fifth register
    a_write_cap7_field: assert property (
        s_write_taken and (hit_idx == IDX_W'(SRC_REG[SRC_CAPTURE7]))
        and avs_req.byteenable[1]
        |=> st.field[SRC_CAPTURE7] == $past(avs_req.writedata[10:8]))
        else $error("capture 7 field not written from bits 10-8");

    // timer four field lands from bits 14-12 of the sixth register
    a_write_tmr4_field: assert property (
        s_write_taken and (hit_idx == IDX_W'(SRC_REG[SRC_TIMER_FOUR]))
        and avs_req.byteenable[1]
        |=> st.field[SRC_TIMER_FOUR] == $past(avs_req.writedata[14:12]))
        else $error("timer four field not written from bits 14-12");

    // compare 4 field lands from bits 10-8 of the sixth register
    a_write_cmp4_field: assert property (
        s_write_taken and (hit_idx == IDX_W'(SRC_REG[SRC_CMP4]))
        and avs_req.byteenable[1]
        |=> st.field[SRC_CMP4] == $past(avs_req.writedata[10:8]))
        else $error("compare 4 field not written from bits 10-8");

    // uart B transmit field lands from bits 14-12 of the seventh register
    a_write_uartb_tx: assert property (
        s_write_taken and (hit_idx == IDX_W'(SRC_REG[SRC_UART_B_TX]))
        and avs_req.byteenable[1]
        |=> st.field[SRC_UART_B_TX] == $past(avs_req.writedata[14:12]))
        else $error("uart B transmit field not written from bits 14-12");

    // uart B receive field lands from bits 10-8 of the seventh register
    a_write_uartb_rx: assert property (
        s_write_taken and (hit_idx == IDX_W'(SRC_REG[SRC_UART_B_RX]))
        and avs_req.byteenable[1]
        |=> st.field[SRC_UART_B_RX] == $past(avs_req.writedata[10:8]))
        else $error("uart B receive field not written from bits 10-8");

    // external two field lands from bits 6-4 of the seventh register
    a_write_ext2_field: assert property (
        s_write_taken and (hit_idx == IDX_W'(SRC_REG[SRC_EXT_TWO]))
        and avs_req.byteenable[0]
        |=> st.field[SRC_EXT_TWO] == $past(avs_req.writedata[6:4]))
        else $error("external two field not written from bits 6-4");

    // spi event field lands from bits 6-4 of the eighth register
    a_write_spi_event: assert property (
        s_write_taken and (hit_idx == IDX_W'(SRC_REG[SRC_SPI_EVENT]))
        and avs_req.byteenable[0]
        |=> st.field[SRC_SPI_EVENT] == $past(avs_req.writedata[6:4]))
        else $error("spi event field not written from bits 6-4");

    // per-source checks on level, gating and write isolation
    generate
        for (g = 0; g < NUM_SRC; g++) begin : g_chk
            a_level_seven_top: assert property (
                st.field[g] == PRIO_HIGH |=> src_level[g] == PRIO_HIGH)
                else $error("code seven not at level seven");
            a_level_one_low: assert property (
                st.field[g] == PRIO_LOW |=> src_level[g] == PRIO_LOW)
                else $error("code one not at level one");
            a_zero_blocks_req: assert property (
                st.field[g] == PRIO_OFF |=> !src_req[g])
                else $error("disabled source raised a request");
            a_active_raises_req: assert property (
                src_flag[g] && src_enable[g] && st.field[g] != PRIO_OFF
                |=> src_req[g])
                else $error("active source did not raise a request");
            a_other_field_stable: assert property (
                !(avs_req.write && !avs_waitrequest && (int'(hit_idx) == SRC_REG[g]))
                |=> $stable(st.field[g]))
                else $error("field changed without a write to it");
        end
    endgenerate

endmodule : ipf_prio_bank
`default_nettype wire

// file: ipf_src_gate.sv
// one source: priority code to level and gated request
`timescale 1ns/10ps
`default_nettype none
module ipf_src_gate (
    input  wire logic          src_flag,
    input  wire logic          src_enable,
    input  wire ipf_pkg::ipf_prio_t code,
    output logic               request,
    output ipf_pkg::ipf_prio_t level
);
    import ipf_pkg::*;

    // code is the level itself: 7 highest, 1 lowest, 0 off
    always_comb begin
        level   = code;
        request = src_flag && src_enable && (code != PRIO_OFF);
    end

endmodule : ipf_src_gate
`default_nettype wire

// file: ipf_tb.sv
// self-checking bench for the priority field bank
`timescale 1ns/10ps
`default_nettype none
module tb;
    import ipf_pkg::*;

    `define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin error_cnt++; \
        $display("mismatch at %0t: got %0h expected %0h", $time, got, exp); end end

    // implemented field bits of each register, and where each source sits
    localparam logic [15:0] MASK [NUM_REG] =
        '{16'h0077, 16'h7777, 16'h7707, 16'h7770, 16'h7777, 16'h0077};
    localparam int POS_REG [NUM_SRC] = '{0, 0, 1, 1, 1, 1, 2, 2, 2, 3, 3, 3, 4, 4, 4, 4, 5, 5};
    localparam int POS_LSB [NUM_SRC] = '{4, 0, 12, 8, 4, 0, 12, 8, 0, 12, 8, 4, 12, 8, 4, 0, 4, 0};

    logic                clk;
    logic                sys_rst;
    ipf_avs_req_s        avs_req;
    logic [DATA_W-1:0]   avs_readdata;
    logic                avs_waitrequest;
    logic [NUM_SRC-1:0]  src_flag;
    logic [NUM_SRC-1:0]  src_enable;
    logic [NUM_SRC-1:0]  src_req;
    ipf_fields_t         src_level;
    ipf_prio_t           code_q [NUM_SRC];
    logic [DATA_W-1:0]   rd;
    int                  error_cnt;
    int                  n_tests;

    ipf_prio_bank i_dut (
        .clk             (clk),
        .sys_rst         (sys_rst),
        .avs_req         (avs_req),
        .avs_readdata    (avs_readdata),
        .avs_waitrequest (avs_waitrequest),
        .src_flag        (src_flag),
        .src_enable      (src_enable),
        .src_req         (src_req),
        .src_level       (src_level)
    );

    // 10 MHz clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // verdict and end of run
    task automatic summarize;
        $display("comparisons %0d, mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : summarize

    // one avalon access; holds the request until waitrequest is seen low at an edge
    task automatic xfer(input logic wr, input logic [ADDR_W-1:0] addr,
                        input logic [DATA_W-1:0] wd, input logic [BE_W-1:0] be);
        bit done;
        done = 1'b0;
        @(posedge clk);
        avs_req <= '{read: ~wr, write: wr, address: addr, writedata: wd, byteenable: be};
        // waitrequest and read data are taken at the rising edge that sees the stall low
        for (int i = 0; i < 20 && !done; i++) begin
            @(posedge clk);
            if (avs_waitrequest === 1'b0) begin
                rd = avs_readdata;
                done = 1'b1;
            end
        end
        if (!done) begin
            error_cnt++;
            $display("mismatch at %0t: no answer from the bus", $time);
            summarize();
        end
        avs_req.read  <= 1'b0;
        avs_req.write <= 1'b0;
    endtask : xfer

    // register word that the expected codes give
    function automatic logic [15:0] reg_word(input int r);
        logic [15:0] w;
        w = 16'h0000;
        for (int s = 0; s < NUM_SRC; s++) begin
            if (POS_REG[s] == r) w |= 16'(code_q[s]) << POS_LSB[s];
        end
        return w;
    endfunction : reg_word

    // read every register back and compare
    task automatic check_regs;
        for (int r = 0; r < NUM_REG; r++) begin
            xfer(1'b0, ADDR_W'(r * 4), 32'h0, 4'hF);
            `CHK(rd, {16'h0000, reg_word(r)})
        end
    endtask : check_regs

    // levels and gated requests after they settle
    task automatic check_out;
        repeat (3) @(posedge clk);
        @(negedge clk);
        for (int s = 0; s < NUM_SRC; s++) begin
            `CHK(src_level[s], code_q[s])
            `CHK(src_req[s], src_flag[s] & src_enable[s] & (code_q[s] != 3'h0))
        end
    endtask : check_out

    task automatic do_reset(input int n);
        @(posedge clk);
        sys_rst <= 1'b1;
        repeat (n) @(posedge clk);
        sys_rst <= 1'b0;
        foreach (code_q[s]) code_q[s] = PRIO_RESET;
    endtask : do_reset

    // main sequence
    initial begin
        error_cnt  = 0;
        n_tests    = 0;
        sys_rst    = 1'b1;
        avs_req    = '0;
        src_flag   = '1;
        src_enable = '1;
        do_reset(20);
        check_regs();
        check_out();
        // all ones, unused bits included
        for (int r = 0; r < NUM_REG; r++) xfer(1'b1, ADDR_W'(r * 4), 32'hFFFFFFFF, 4'hF);
        foreach (code_q[s]) code_q[s] = PRIO_HIGH;
        check_regs();
        check_out();
        // every code on every source, with varied gating
        for (int c = 0; c < 8; c++) begin
            foreach (code_q[s]) code_q[s] = 3'((s + c) % 8);
            src_flag   <= 18'h3FFFF ^ (18'h5 << c);
            src_enable <= 18'h3FFFF ^ (18'h3 << (2 * c));
            for (int r = 0; r < NUM_REG; r++) begin
                xfer(1'b1, ADDR_W'(r * 4), {16'hFFFF, reg_word(r) | ~MASK[r]}, 4'hF);
            end
            check_regs();
            check_out();
        end
        // one byte lane per register
        for (int r = 0; r < NUM_REG; r++) begin
            xfer(1'b1, ADDR_W'(r * 4), 32'h0, 4'hF);
            xfer(1'b1, ADDR_W'(r * 4), 32'hFFFFFFFF, 4'h1 << (r % 2));
            for (int s = 0; s < NUM_SRC; s++) begin
                if (POS_REG[s] == r) code_q[s] = ((POS_LSB[s] >= 8) == (r % 2 == 1)) ? 3'h7 : 3'h0;
            end
        end
        check_regs();
        check_out();
        // unmapped words read zero and ignore writes
        xfer(1'b1, 5'h18, 32'hFFFFFFFF, 4'hF);
        xfer(1'b0, 5'h18, 32'h0, 4'hF);
        `CHK(rd, 32'h0)
        xfer(1'b0, 5'h1C, 32'h0, 4'hF);
        `CHK(rd, 32'h0)
        check_regs();
        // second reset in mid-run
        do_reset(2);
        check_regs();
        check_out();
        summarize();
    end
endmodule : tb
`default_nettype wire
